// [core/param_access.sv]
// Purpose: Interprets decoded link commands against the parameter table.
// Assumes: Frames are already parsed; one command per cmd_valid pulse.
// Notes:   Summary of operation follows.
//
// The register offsets and the plain strobed port were left to the implementer.
module param_access
  import param_access_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic        cmd_bcast,
  input  wire logic        cmd_loop2,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [15:0] cmd_data,
  output logic             rsp_valid,
  output logic      [7:0]  rsp_code_hi,
  output logic      [7:0]  rsp_code_lo,
  output logic      [15:0] rsp_data,
  input  wire logic        key_valid,
  input  wire logic [2:0]  key_index,
  input  wire logic [15:0] key_data,
  input  wire logic        key_local_req,
  output logic             key_reject,
  input  wire logic [3:0]  option_fitted,
  input  wire logic        bcc_clear,
  input  wire logic        bcc_byte_valid,
  input  wire logic [7:0]  bcc_byte,
  output logic      [7:0]  bcc_value,
  output logic      [7:0]  frame_start_char,
  output logic      [7:0]  frame_end_char,
  output logic             frame_lf_en,
  output logic             remote_lamp,
  output logic             mode_exclusive
);

  // ==========================================================================
  // Storage and settings
  // ==========================================================================
  logic [15:0] par_reg [2][8];
  logic [15:0] opt_reg [4];
  logic [1:0]  frame_reg;
  logic [1:0]  bcc_sel_reg;
  logic [7:0]  sum_reg;
  logic [7:0]  xor_reg;

  logic remote_lamp_q;
  logic excl_q;
  assign remote_lamp = remote_lamp_q;
  assign mode_exclusive = excl_q;

  // ==========================================================================
  // Command decode
  // ==========================================================================
  logic        hit_par;
  logic        hit_rsv;
  logic        hit_opt;
  logic        hit_ro;
  logic        hit_mode;
  logic        hit_type;
  logic        opt_missing;
  logic        access_err;
  logic        mode_refuse;
  logic        range_err;
  logic        do_write;
  logic        link_wr_ok;
  logic [7:0]  code_lo_next;
  logic [15:0] read_next;
  logic [2:0]  idx;

  assign idx        = cmd_addr[2:0];
  assign link_wr_ok = !excl_q || remote_lamp_q;

  always_comb
  begin
    hit_par     = (cmd_addr[15:3] == PAR_BASE_HI);
    hit_rsv     = (cmd_addr[15:3] == RSV_BASE_HI);
    hit_opt     = (cmd_addr[15:3] == OPT_BASE_HI) && !idx[2];
    hit_ro      = (cmd_addr == ADDR_MODE_FLAGS) || (cmd_addr == ADDR_OPT_FLAGS);
    hit_mode    = (cmd_addr == ADDR_COMM_MODE);
    hit_type    = (cmd_addr == ADDR_MODE_TYPE);
    opt_missing = hit_opt && !option_fitted[idx[1:0]];
    // Second loop reaches per-loop parameters and the reserved block only; others treat it as bad address, except absent options, which report the option error.
    access_err  = (cmd_loop2 && !hit_par && !hit_rsv)
                || (cmd_write && hit_ro)
                || (!cmd_write && hit_mode);
    // Mode writes bypass the exclusive gate so the link can always reach remote; type writes of 0 are refused in exclusive local mode.
    mode_refuse = cmd_write && ((hit_par || hit_opt) && !link_wr_ok
                || hit_type && cmd_data == 16'h0000 && excl_q && !remote_lamp_q);
    range_err   = 1'b0;
    if (cmd_write && (hit_mode || hit_type) && cmd_data > 16'h0001)
      range_err = 1'b1;
    if (cmd_write && hit_par && idx == PAR_TIME_IDX)
      range_err = (cmd_data[7:4] > 4'h5) || (cmd_data[3:0] > 4'h9)
                || (cmd_data[15:12] > 4'h9) || (cmd_data[11:8] > 4'h9);
    if (opt_missing)
      code_lo_next = CODE_OPT_ERR;
    else if (access_err)
      code_lo_next = CODE_ADDR_ERR;
    else if (mode_refuse)
      code_lo_next = CODE_MODE_ERR;
    else if (range_err)
      code_lo_next = CODE_RANGE;
    else
      code_lo_next = CODE_ZERO;
    // Broadcast touches only broadcast-capable addresses.
    do_write = cmd_valid && cmd_write && code_lo_next == CODE_ZERO
             && (!cmd_bcast || hit_par || hit_mode);
    read_next = 16'h0000;
    if (hit_par)
      read_next = par_reg[cmd_loop2][idx];
    else if (hit_opt)
      read_next = opt_reg[idx[1:0]];
    else if (cmd_addr == ADDR_MODE_FLAGS)
      read_next = {14'h0000, excl_q, remote_lamp_q};
    else if (cmd_addr == ADDR_OPT_FLAGS)
      read_next = {12'h000, option_fitted};
    else if (hit_type)
      read_next = {15'h0000, excl_q};
  end

  // ==========================================================================
  // Response
  // ==========================================================================
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      rsp_valid   <= 1'b0;
      rsp_code_hi <= CODE_ZERO;
      rsp_code_lo <= CODE_ZERO;
      rsp_data    <= 16'h0000;
    end
    else
    begin
      rsp_valid <= cmd_valid && !cmd_bcast;
      if (cmd_valid)
      begin
        rsp_code_hi <= CODE_ZERO;
        rsp_code_lo <= code_lo_next;
        rsp_data    <= (cmd_write || code_lo_next != CODE_ZERO) ? 16'h0000 : read_next;
      end
    end
  end

  // ==========================================================================
  // Parameter table
  // ==========================================================================
  logic key_ok;
  assign key_ok = !excl_q || !remote_lamp_q;

  // Values are stored as raw 16-bit words; signedness, decimal point and
  // byte packing of entry seven belong to the consumer.
  genvar g_loop, g_idx;
  generate
    for (g_loop = 0; g_loop < 2; g_loop++)
    begin : g_loops
      for (g_idx = 0; g_idx < 8; g_idx++)
      begin : g_entries
        always_ff @(posedge core_clk)
        begin
          if (srst)
            par_reg[g_loop][g_idx] <= PAR_RESET;
          else if (do_write && hit_par && idx == 3'(g_idx) && (cmd_bcast || cmd_loop2 == 1'(g_loop)))
            par_reg[g_loop][g_idx] <= cmd_data;
          else if (g_loop == 0 && key_valid && key_ok && key_index == 3'(g_idx))
            par_reg[g_loop][g_idx] <= key_data;
        end
      end
    end
    for (g_idx = 0; g_idx < 4; g_idx++)
    begin : g_opts
      always_ff @(posedge core_clk)
      begin
        if (srst)
          opt_reg[g_idx] <= PAR_RESET;
        else if (do_write && hit_opt && idx[1:0] == 2'(g_idx))
          opt_reg[g_idx] <= cmd_data;
      end
    end
  endgenerate

  always_ff @(posedge core_clk)
  begin
    if (srst)
      key_reject <= 1'b0;
    else
      key_reject <= key_valid && !key_ok;
  end

  // ==========================================================================
  // Mode and mode type
  // ==========================================================================
  always_ff @(posedge core_clk)
  begin
    if (srst)
      remote_lamp_q <= 1'b0;
    else if (do_write && hit_mode)
      remote_lamp_q <= cmd_data[0];
    else if (key_local_req)
      remote_lamp_q <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      excl_q <= 1'b0;
    else if (do_write && hit_type)
      excl_q <= cmd_data[0];
  end

  // ==========================================================================
  // Software registers
  // ==========================================================================
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      frame_reg   <= FRAME_RESET;
      bcc_sel_reg <= BCC_RESET;
    end
    else if (reg_wr && reg_addr == REG_CONFIG)
    begin
      if (reg_wdata[CFG_FRAME_LSB +: 2] != 2'h3)
        frame_reg <= reg_wdata[CFG_FRAME_LSB +: 2];
      bcc_sel_reg <= reg_wdata[CFG_BCC_LSB +: 2];
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd && reg_addr == REG_CONFIG)
      reg_rdata <= {28'h0000000, bcc_sel_reg, frame_reg};
    else if (reg_rd && reg_addr == REG_STATUS)
      reg_rdata <= {30'h0, excl_q, remote_lamp_q};
    else
      reg_rdata <= 32'h0000_0000;
  end

  // ==========================================================================
  // Framing characters
  // ==========================================================================
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      frame_start_char <= CHAR_STX;
      frame_end_char   <= CHAR_ETX;
      frame_lf_en      <= 1'b0;
    end
    else
    begin
      frame_start_char <= (frame_reg == FRAME_AT_COLON_CR) ? CHAR_AT : CHAR_STX;
      frame_end_char   <= (frame_reg == FRAME_AT_COLON_CR) ? CHAR_COLON : CHAR_ETX;
      frame_lf_en      <= (frame_reg == FRAME_STX_ETX_CRLF);
    end
  end

  // ==========================================================================
  // Block check character
  // ==========================================================================
  always_ff @(posedge core_clk)
  begin
    if (srst || bcc_clear)
    begin
      sum_reg <= 8'h00;
      xor_reg <= 8'h00;
    end
    else if (bcc_byte_valid)
    begin
      sum_reg <= 8'(sum_reg + bcc_byte);
      xor_reg <= xor_reg ^ bcc_byte;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
      bcc_value <= 8'h00;
    else
    begin
      unique case (bcc_sel_t'(bcc_sel_reg))
        BCC_ADD:  bcc_value <= sum_reg;
        BCC_TWOS: bcc_value <= 8'(8'h00 - sum_reg);
        BCC_XOR:  bcc_value <= xor_reg;
        BCC_NONE: bcc_value <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  frame_map_a: assert property (@(posedge core_clk) disable iff (srst)
    ##1 $past(frame_reg) == FRAME_AT_COLON_CR |-> frame_start_char == CHAR_AT && frame_end_char == CHAR_COLON)
    else $error("framing characters do not follow the setting");

  bcc_twos_a: assert property (@(posedge core_clk) disable iff (srst)
    ##1 $past(bcc_sel_reg) == BCC_TWOS |-> 8'(bcc_value + $past(sum_reg)) == 8'h00)
    else $error("complement check character wrong");

  ro_write_a: assert property (@(posedge core_clk) disable iff (srst)
    cmd_valid && cmd_write && !cmd_bcast && cmd_addr == ADDR_MODE_FLAGS
    |=> rsp_valid && rsp_code_hi == 8'h30 && rsp_code_lo == 8'h38)
    else $error("read-only write not answered with address error");

  rsv_read_a: assert property (@(posedge core_clk) disable iff (srst)
    cmd_valid && !cmd_write && !cmd_bcast && !cmd_loop2 && (cmd_addr[15:3] == RSV_BASE_HI || cmd_addr == 16'h0500)
    |=> rsp_valid && rsp_data == 16'h0000 && rsp_code_lo == 8'h30)
    else $error("unlisted read did not return zero");

  rsv_write_a: assert property (@(posedge core_clk) disable iff (srst)
    cmd_valid && cmd_write && !cmd_bcast && !cmd_loop2 && cmd_addr[15:3] == RSV_BASE_HI
    |=> rsp_code_lo == 8'h30 && $stable(par_reg[0][0]))
    else $error("reserved write not answered normally");

  opt_err_a: assert property (@(posedge core_clk) disable iff (srst)
    cmd_valid && !cmd_bcast && cmd_addr == 16'h0401 && !option_fitted[1]
    |=> rsp_code_hi == 8'h30 && rsp_code_lo == 8'h43)
    else $error("absent option not reported");

  time_err_a: assert property (@(posedge core_clk) disable iff (srst)
    cmd_valid && cmd_write && !cmd_loop2 && cmd_addr == 16'h0306 && cmd_data[7:0] >= 8'h60
    && !key_valid |=> $stable(par_reg[0][6]))
    else $error("bad time value was stored");

  key_gate_a: assert property (@(posedge core_clk) disable iff (srst)
    key_valid && excl_q && remote_lamp_q |=> key_reject ##1 !key_reject || $past(key_valid))
    else $error("key edit accepted in exclusive remote mode");

  type_back_a: assert property (@(posedge core_clk) disable iff (srst)
    cmd_valid && cmd_write && cmd_addr == ADDR_MODE_TYPE && excl_q && !remote_lamp_q |=> excl_q)
    else $error("mode type returned to permissive in local mode");

  enter_remote_a: assert property (@(posedge core_clk) disable iff (srst)
    !remote_lamp_q && !(cmd_valid && cmd_write && cmd_addr == ADDR_COMM_MODE) |=> !remote_lamp_q)
    else $error("remote mode entered without link command");

  remote_cov: cover property (@(posedge core_clk) disable iff (srst) !remote_lamp_q ##1 remote_lamp_q);
  excl_cov: cover property (@(posedge core_clk) disable iff (srst) !excl_q ##1 excl_q);
  reject_cov: cover property (@(posedge core_clk) disable iff (srst) key_reject);
  bcast_cov: cover property (@(posedge core_clk) disable iff (srst) cmd_valid && cmd_bcast && do_write);

endmodule : param_access

// [common/param_access_pkg.sv]
// Purpose: Shared constants for the serial parameter access interpreter.
// Assumes: One 25 MHz clock, synchronous active-high reset.
// Notes:   Response codes are ASCII characters sent by the framing logic.
package param_access_pkg;

  // ==========================================================================
  // Settings encodings
  // ==========================================================================
  typedef enum logic [1:0] {FRAME_STX_ETX_CR = 2'h0, FRAME_STX_ETX_CRLF = 2'h1, FRAME_AT_COLON_CR = 2'h2}
    frame_sel_t;
  typedef enum logic [1:0] {BCC_ADD = 2'h0, BCC_TWOS = 2'h1, BCC_XOR = 2'h2, BCC_NONE = 2'h3} bcc_sel_t;

  // ==========================================================================
  // Software register port
  // ==========================================================================
  localparam logic [3:0]  REG_CONFIG     = 4'h0;
  localparam logic [3:0]  REG_STATUS     = 4'h4;
  localparam int          CFG_FRAME_LSB  = 0;
  localparam int          CFG_BCC_LSB    = 2;
  localparam int          ST_REMOTE_BIT  = 0;
  localparam int          ST_EXCL_BIT    = 1;
  localparam logic [1:0]  FRAME_RESET    = 2'h0;
  localparam logic [1:0]  BCC_RESET      = 2'h0;

  // ==========================================================================
  // Data address map
  // ==========================================================================
  localparam logic [15:0] ADDR_MODE_FLAGS = 16'h0100;
  localparam logic [15:0] ADDR_OPT_FLAGS  = 16'h0101;
  localparam logic [15:0] ADDR_COMM_MODE  = 16'h018c;
  localparam logic [15:0] ADDR_MODE_TYPE  = 16'h018e;
  localparam logic [12:0] PAR_BASE_HI     = 13'h0060;
  localparam logic [12:0] RSV_BASE_HI     = 13'h0061;
  localparam logic [12:0] OPT_BASE_HI     = 13'h0080;
  localparam logic [2:0]  PAR_TIME_IDX    = 3'h6;
  localparam logic [2:0]  PAR_PACKED_IDX  = 3'h7;

  // ==========================================================================
  // Response codes and characters
  // ==========================================================================
  localparam logic [7:0]  CODE_ZERO     = 8'h30;
  localparam logic [7:0]  CODE_ADDR_ERR = 8'h38;
  localparam logic [7:0]  CODE_RANGE    = 8'h39;
  localparam logic [7:0]  CODE_OPT_ERR  = 8'h43;
  localparam logic [7:0]  CODE_MODE_ERR = 8'h44;
  localparam logic [7:0]  CHAR_STX      = 8'h02;
  localparam logic [7:0]  CHAR_ETX      = 8'h03;
  localparam logic [7:0]  CHAR_CR       = 8'h0d;
  localparam logic [7:0]  CHAR_AT       = 8'h40;
  localparam logic [7:0]  CHAR_COLON    = 8'h3a;
  localparam logic [15:0] PAR_RESET     = 16'h0000;

endpackage : param_access_pkg

// [bench/host_link_model.sv]
// Purpose: Host computer model that issues decoded link commands and frame bytes.
// Assumes: Requests start just after a rising edge and are held for one clock cycle.
// Notes:   Released address and data lines carry inverted values, never stale ones.
module host_link_model
(
  input  wire logic        core_clk,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic             cmd_bcast,
  output logic             cmd_loop2,
  output logic      [15:0] cmd_addr,
  output logic      [15:0] cmd_data,
  output logic             bcc_clear,
  output logic             bcc_byte_valid,
  output logic      [7:0]  bcc_byte,
  input  wire logic        rsp_valid,
  input  wire logic [7:0]  rsp_code_hi,
  input  wire logic [7:0]  rsp_code_lo,
  input  wire logic [15:0] rsp_data
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    {cmd_valid, cmd_write, cmd_bcast, cmd_loop2, bcc_clear, bcc_byte_valid} = 6'h00;
    {cmd_addr, cmd_data, bcc_byte} = 40'h0;
  end

  // ==========================================================================
  // Command transfer
  // ==========================================================================
  task automatic command(input logic [2:0] op, input logic [15:0] a, input logic [15:0] d,
                         output logic got, output logic [7:0] hi, output logic [7:0] lo,
                         output logic [15:0] rd);
    @(posedge core_clk);
    cmd_valid <= 1'h1;
    cmd_write <= op[2];
    cmd_bcast <= op[1];
    cmd_loop2 <= op[0];
    cmd_addr  <= a;
    cmd_data  <= d;
    @(posedge core_clk);
    cmd_valid <= 1'h0;
    cmd_addr  <= ~a;
    cmd_data  <= ~d;
    #1;
    got = rsp_valid;
    hi  = rsp_code_hi;
    lo  = rsp_code_lo;
    rd  = rsp_data;
  endtask : command

  // Sends three frame bytes after clearing the check accumulators.
  task automatic send_bytes(input logic [23:0] b);
    @(posedge core_clk);
    bcc_clear <= 1'h1;
    for (int i = 2; i >= 0; i--)
    begin
      @(posedge core_clk);
      bcc_clear      <= 1'h0;
      bcc_byte_valid <= 1'h1;
      bcc_byte       <= b[i*8 +: 8];
    end
    @(posedge core_clk);
    bcc_byte_valid <= 1'h0;
    bcc_byte       <= ~b[7:0];
    repeat (2) @(posedge core_clk);
    #1;
  endtask : send_bytes
endmodule : host_link_model

// [bench/tb_top.sv]
// Purpose: Self-checking bench for the parameter access interpreter.
// Assumes: 25 MHz clock, synchronous active-high reset.
// Notes:   Table rows cover link commands; mode gates and settings follow by hand.
module tb_top
  import param_access_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [2:0] op; logic [15:0] a; logic [15:0] d; logic [7:0] lo; logic [15:0] rd;} row_t;

  logic        core_clk = 1'h0;
  logic        srst = 1'h1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic        key_valid = 1'h0;
  logic [2:0]  key_index = 3'h0;
  logic [15:0] key_data = 16'h0;
  logic        key_local_req = 1'h0;
  logic [3:0]  option_fitted = 4'h0;
  logic [31:0] reg_rdata;
  logic        cmd_valid, cmd_write, cmd_bcast, cmd_loop2, rsp_valid, key_reject;
  logic [15:0] cmd_addr, cmd_data, rsp_data;
  logic [7:0]  rsp_code_hi, rsp_code_lo, bcc_byte, bcc_value, frame_start_char, frame_end_char;
  logic        bcc_clear, bcc_byte_valid, frame_lf_en, remote_lamp, mode_exclusive;
  int          errors = 0;
  int          total_checks = 0;
  logic [7:0]  bcc_exp [4] = '{8'h46, 8'hba, 8'h20, 8'h00};
  logic [1:0]  fp;
  // Op bits: write, broadcast, second loop.
  row_t rows [29] = '{
    '{3'h4, 16'h0300, 16'h8000, 8'h30, 16'h0000},
    '{3'h0, 16'h0300, 16'h0000, 8'h30, 16'h8000},
    '{3'h5, 16'h0300, 16'h7fff, 8'h30, 16'h0000},
    '{3'h1, 16'h0300, 16'h0000, 8'h30, 16'h7fff},
    '{3'h0, 16'h0300, 16'h0000, 8'h30, 16'h8000},
    '{3'h4, 16'h0100, 16'h0001, 8'h38, 16'h0000},
    '{3'h4, 16'h0308, 16'h1234, 8'h30, 16'h0000},
    '{3'h0, 16'h0308, 16'h0000, 8'h30, 16'h0000},
    '{3'h0, 16'h0500, 16'h0000, 8'h30, 16'h0000},
    '{3'h4, 16'h0306, 16'h0059, 8'h30, 16'h0000},
    '{3'h4, 16'h0306, 16'h0060, 8'h39, 16'h0000},
    '{3'h4, 16'h0306, 16'h005a, 8'h39, 16'h0000},
    '{3'h0, 16'h0306, 16'h0000, 8'h30, 16'h0059},
    '{3'h4, 16'h0306, 16'h9959, 8'h30, 16'h0000},
    '{3'h0, 16'h0306, 16'h0000, 8'h30, 16'h9959},
    '{3'h4, 16'h0307, 16'h0108, 8'h30, 16'h0000},
    '{3'h0, 16'h0307, 16'h0000, 8'h30, 16'h0108},
    '{3'h0, 16'h0401, 16'h0000, 8'h43, 16'h0000},
    '{3'h4, 16'h0401, 16'h0005, 8'h43, 16'h0000},
    '{3'h4, 16'h0400, 16'h0005, 8'h30, 16'h0000},
    '{3'h0, 16'h0400, 16'h0000, 8'h30, 16'h0005},
    '{3'h1, 16'h0400, 16'h0000, 8'h38, 16'h0000},
    '{3'h1, 16'h0401, 16'h0000, 8'h43, 16'h0000},
    '{3'h4, 16'h018e, 16'h0002, 8'h39, 16'h0000},
    '{3'h6, 16'h0301, 16'h0011, 8'h30, 16'h0000},
    '{3'h1, 16'h0301, 16'h0000, 8'h30, 16'h0011},
    '{3'h6, 16'h0100, 16'h0005, 8'h30, 16'h0000},
    '{3'h0, 16'h0101, 16'h0000, 8'h30, 16'h0001},
    '{3'h0, 16'h018c, 16'h0000, 8'h38, 16'h0000}};

  always #20 core_clk = ~core_clk;

  param_access param_access_inst (.core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_bcast(cmd_bcast), .cmd_loop2(cmd_loop2), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_code_hi(rsp_code_hi), .rsp_code_lo(rsp_code_lo), .rsp_data(rsp_data),
    .key_valid(key_valid), .key_index(key_index), .key_data(key_data), .key_local_req(key_local_req),
    .key_reject(key_reject), .option_fitted(option_fitted), .bcc_clear(bcc_clear),
    .bcc_byte_valid(bcc_byte_valid), .bcc_byte(bcc_byte), .bcc_value(bcc_value),
    .frame_start_char(frame_start_char), .frame_end_char(frame_end_char), .frame_lf_en(frame_lf_en),
    .remote_lamp(remote_lamp), .mode_exclusive(mode_exclusive));

  host_link_model host_link_model_inst (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_bcast(cmd_bcast), .cmd_loop2(cmd_loop2), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .bcc_clear(bcc_clear), .bcc_byte_valid(bcc_byte_valid), .bcc_byte(bcc_byte), .rsp_valid(rsp_valid),
    .rsp_code_hi(rsp_code_hi), .rsp_code_lo(rsp_code_lo), .rsp_data(rsp_data));

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic check_word(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : check_word

  task automatic cmd(input logic [2:0] op, input logic [15:0] a, input logic [15:0] d,
                     input logic [7:0] lo, input logic [15:0] rd);
    logic       got;
    logic [7:0] h, l;
    logic [15:0] r;
    host_link_model_inst.command(op, a, d, got, h, l, r);
    check_word("rsp_valid", {31'h0, ~op[1]}, {31'h0, got});
    if (!op[1])
    begin
      check_word("rsp_code_hi", CODE_ZERO, h);
      check_word("rsp_code_lo", lo, l);
      check_word("rsp_data", rd, r);
    end
  endtask : cmd

  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge core_clk);
    reg_wr    <= 1'h0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge core_clk);
    reg_rd   <= 1'h0;
    #1 check_word("reg_rdata", e, reg_rdata);
  endtask : reg_read

  task automatic key_edit(input logic [2:0] i, input logic [15:0] d, input logic rej);
    @(posedge core_clk);
    key_valid <= 1'h1;
    key_index <= i;
    key_data  <= d;
    @(posedge core_clk);
    key_valid <= 1'h0;
    #1 check_word("key_reject", {31'h0, rej}, {31'h0, key_reject});
  endtask : key_edit

  task automatic key_local;
    @(posedge core_clk);
    key_local_req <= 1'h1;
    @(posedge core_clk);
    key_local_req <= 1'h0;
    #1 check_word("remote_lamp", 32'h0, {31'h0, remote_lamp});
  endtask : key_local

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    repeat (3) @(posedge core_clk);
    srst          <= 1'h0;
    option_fitted <= 4'h1;
    reg_read(REG_CONFIG, 32'h0);
    reg_read(4'h8, 32'h0);
    foreach (rows[k]) cmd(rows[k].op, rows[k].a, rows[k].d, rows[k].lo, rows[k].rd);
    $display("test table done");
    cmd(3'h4, ADDR_COMM_MODE, 16'h0001, 8'h30, 16'h0);
    key_edit(3'h2, 16'h0aaa, 1'h0);
    key_local;
    cmd(3'h0, 16'h0302, 16'h0, 8'h30, 16'h0aaa);
    cmd(3'h4, ADDR_MODE_TYPE, 16'h0001, 8'h30, 16'h0);
    check_word("mode_exclusive", 32'h1, {31'h0, mode_exclusive});
    cmd(3'h4, 16'h0300, 16'h0001, CODE_MODE_ERR, 16'h0);
    key_edit(3'h3, 16'h0bbb, 1'h0);
    cmd(3'h4, ADDR_MODE_TYPE, 16'h0000, CODE_MODE_ERR, 16'h0);
    cmd(3'h4, 16'h0306, 16'h0060, CODE_MODE_ERR, 16'h0);
    cmd(3'h4, ADDR_MODE_TYPE, 16'h0002, CODE_RANGE, 16'h0);
    cmd(3'h4, ADDR_COMM_MODE, 16'h0001, 8'h30, 16'h0);
    key_edit(3'h3, 16'h0ccc, 1'h1);
    cmd(3'h0, 16'h0303, 16'h0, 8'h30, 16'h0bbb);
    cmd(3'h4, 16'h0300, 16'h0002, 8'h30, 16'h0);
    reg_read(REG_STATUS, 32'h3);
    cmd(3'h4, ADDR_MODE_TYPE, 16'h0000, 8'h30, 16'h0);
    cmd(3'h4, ADDR_COMM_MODE, 16'h0000, 8'h30, 16'h0);
    reg_read(REG_STATUS, 32'h0);
    $display("test mode gates done");
    reg_write(4'hc, 32'hffffffff);
    for (int i = 0; i < 4; i++)
    begin
      reg_write(REG_CONFIG, {28'h0, i[1:0], i[1:0]});
      fp = (i == 3) ? 2'h2 : i[1:0];
      reg_read(REG_CONFIG, {28'h0, i[1:0], fp});
      check_word("frame_start_char", (fp == 2'h2) ? CHAR_AT : CHAR_STX, frame_start_char);
      check_word("frame_end_char", (fp == 2'h2) ? CHAR_COLON : CHAR_ETX, frame_end_char);
      check_word("frame_lf_en", {31'h0, fp == 2'h1}, {31'h0, frame_lf_en});
      host_link_model_inst.send_bytes(24'h819233);
      check_word("bcc_value", bcc_exp[i], bcc_value);
    end
    $display("test settings done");
    @(posedge core_clk);
    srst <= 1'h1;
    repeat (3) @(posedge core_clk);
    srst <= 1'h0;
    #1 check_word("frame chars", {CHAR_STX, CHAR_ETX}, {frame_start_char, frame_end_char});
    check_word("mode flags", 32'h0, {frame_lf_en, remote_lamp, mode_exclusive});
    reg_read(REG_CONFIG, 32'h0);
    cmd(3'h0, 16'h0300, 16'h0, 8'h30, PAR_RESET);
    $display("test reset done");
    print_verdict;
  end

  initial
  begin
    repeat (5000) @(posedge core_clk);
    errors++;
    print_verdict;
  end
endmodule : tb_top
